// ---- inc/process_signal_computer_pkg.sv ----
// Contract
// - Moving average outputs the mean of 40 samples taken every L/40.
// - Each new averaging sample replaces the oldest and the mean is recomputed.
// - Output is interpolated between samples instead of stepping.
// - Averaging times of 1, 2 and 3 s use 10, 20 and 30 samples.
// - Averaging time 0 to 320000 s, four digits, 1 s or 0.1 s steps.
// - A nonzero input lag constant filters the input; range 0 to 799.0 s. The code applies it only in averaging, dead time and velocity modes.
// - Dead time stores 40 samples every L/40 and shifts them out interpolated.
// - Dead times of 3, 2 and 1 s use 30, 20 and 10 buffers.
// - Dead time 0 to 320000 s, four digits, 1 s or 0.1 s steps.
// - Lag mode outputs the input through a first-order lag, 0 to 799.0 s.
// - Lead mode outputs input plus high-pass term, X(1 + TS/(1+TS)).
// - Rate mode caps rising and falling slope, else passes the input.
// - Rate limits 0.1 to 699.9 %/min; 700.0 or more disables limiting.
// - Limiter clamps at the exceeded limit; limits -6.0 to 106.0 percent.
// - Upper limit below lower limit drives the output at the upper limit.
// - Velocity outputs 50 percent plus half the change since the last computation.
// - Velocity interval 0 to 320000 s, four digits, 1 s or 0.1 s steps.
// - Reset: rate limits 100 %/min, limits 100 and 0 percent, velocity 20 s.
// - Reset: averaging and dead time 10 s, input lag constant 0 s.
// - One computation step runs every 0.1 s.
// - Both outputs saturate to -6 to 106 percent.
package process_signal_computer_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PCT_W = 16;
   localparam int TIME_W = 24;
   localparam int TC_W = 13;
   localparam int RATE_W = 16;
   localparam int FRAC_W = 8;
   localparam int BUF_DEPTH = 40;
   localparam int PTR_W = 6;

   localparam int COMP_PERIOD_MS = 100;
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_CYCLES_DEF = COMP_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

   localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_AVG_TIME = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DEAD_TIME = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IN_LAG = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_FUNC_TC = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_RATE_UP = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_RATE_DN = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_LIM_HI = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_LIM_LO = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_VEL_TIME = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_INPUT = 8'h2c;

   localparam logic [2:0] MODE_AVG = 3'h0;
   localparam logic [2:0] MODE_DEAD = 3'h1;
   localparam logic [2:0] MODE_LAG = 3'h2;
   localparam logic [2:0] MODE_LEAD = 3'h3;
   localparam logic [2:0] MODE_RATE = 3'h4;
   localparam logic [2:0] MODE_LIMIT = 3'h5;
   localparam logic [2:0] MODE_VEL = 3'h6;

   localparam logic [TIME_W-1:0] TIME_MAX = 24'h30d400;
   localparam logic [TIME_W-1:0] TIME_FINE_MAX = 24'h000028;
   localparam logic [TC_W-1:0] TC_MAX = 13'h1f36;
   localparam logic [RATE_W-1:0] RATE_MIN = 16'h0001;
   localparam logic [RATE_W-1:0] RATE_OPEN = 16'h1b58;
   localparam int RATE_NUM = 2560;
   localparam int RATE_DEN = 600;
   localparam logic signed [PCT_W-1:0] PCT_MIN = -16'sh0258;
   localparam logic signed [PCT_W-1:0] PCT_MAX = 16'sh2968;
   localparam logic signed [31:0] VEL_BIAS = 32'sh00001388;

   localparam logic [2:0] MODE_RST = MODE_AVG;
   localparam logic [TIME_W-1:0] AVG_T_RST = 24'h000064;
   localparam logic [TIME_W-1:0] DEAD_T_RST = 24'h000064;
   localparam logic [TC_W-1:0] IN_LAG_RST = 13'h0000;
   localparam logic [TC_W-1:0] FUNC_TC_RST = 13'h0064;
   localparam logic [RATE_W-1:0] RATE_RST = 16'h03e8;
   localparam logic signed [PCT_W-1:0] LIM_HI_RST = 16'sh2710;
   localparam logic signed [PCT_W-1:0] LIM_LO_RST = 16'sh0000;
   localparam logic [TIME_W-1:0] VEL_T_RST = 24'h0000c8;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_FILTER = 2'b01,
      ST_COMPUTE = 2'b11,
      ST_OUT = 2'b10
   } fsm_t;
endpackage

// ---- tb/input_front_end.sv ----
`timescale 1ns/100ps
module input_front_end (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic signed [process_signal_computer_pkg::PCT_W-1:0] level_i,
   output logic signed [process_signal_computer_pkg::PCT_W-1:0] value_o
);
   import process_signal_computer_pkg::*;
   // The converter result is registered, so a new level reaches the core one clock late.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         value_o <= '0;
      end else begin
         value_o <= level_i;
      end
   end
endmodule

// ---- tb/process_signal_computer_chk.sv ----
`timescale 1ns/100ps
module process_signal_computer_chk #(
   parameter int unsigned TICK_CYCLES = 8
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [process_signal_computer_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [process_signal_computer_pkg::DATA_W-1:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic signed [process_signal_computer_pkg::PCT_W-1:0] primary_output_o,
   input wire logic signed [process_signal_computer_pkg::PCT_W-1:0] secondary_output_o,
   input wire logic result_valid_o
);
   import process_signal_computer_pkg::*;
   logic [31:0] gap_q;
   logic seen_q;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   sequence setup_s; psel_i && !penable_i; endsequence
   sequence bad_s; setup_s ##0 (paddr_i[1:0] != 2'h0 || paddr_i > OFS_INPUT); endsequence
   sequence good_s; setup_s ##0 (paddr_i[1:0] == 2'h0 && paddr_i <= OFS_INPUT); endsequence
   // Cycles since the last result, so the period is checked without a long repetition.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gap_q <= '0;
         seen_q <= 1'b0;
      end else if (result_valid_o) begin
         gap_q <= 32'h1;
         seen_q <= 1'b1;
      end else begin
         gap_q <= gap_q + 32'h1;
      end
   end
   outs_equal_a: assert property (primary_output_o == secondary_output_o)
      else $error("outputs differ");
   out_range_a: assert property (
      primary_output_o >= PCT_MIN && primary_output_o <= PCT_MAX) else $error("output range");
   out_hold_a: assert property ($changed(primary_output_o) |-> result_valid_o)
      else $error("output moved without result");
   valid_pulse_a: assert property (result_valid_o |=> !result_valid_o)
      else $error("result pulse too long");
   valid_period_a: assert property (result_valid_o && seen_q |-> gap_q == TICK_CYCLES)
      else $error("computation period wrong");
   ready_next_a: assert property (setup_s |=> pready_o) else $error("no ready after setup");
   ready_once_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
   err_bad_a: assert property (bad_s |=> pready_o && pslverr_o) else $error("no error");
   err_good_a: assert property (good_s |=> !pslverr_o) else $error("false error");
   err_data_a: assert property (bad_s ##0 !pwrite_i |=> prdata_o == '0)
      else $error("refused read data not zero");
endmodule

bind process_signal_computer process_signal_computer_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .primary_output_o(primary_output_o),
   .secondary_output_o(secondary_output_o), .result_valid_o(result_valid_o)
);

// ---- tb/tb_process_signal_computer.sv ----
`timescale 1ns/100ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_process_signal_computer;
   import process_signal_computer_pkg::*;
   localparam int TICKS = 8;
   logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic pready, pslverr, valid, e;
   logic signed [15:0] level = '0, xin, y1, y2, prev;
   int n_fail = 0, samples_checked = 0;
   int n_win [3] = '{10, 20, 30};
   logic [31:0] rst_v [10] = '{32'h0, 32'h64, 32'h64, 32'h0, 32'h64, 32'h3e8, 32'h3e8,
      32'h2710, 32'h0, 32'hc8};
   logic [31:0] tq_in [3] = '{32'h2d, 32'h186a1, 32'h4c4b40};
   logic [31:0] tq_out [3] = '{32'h28, 32'h186a0, 32'h30d400};

   process_signal_computer #(.TICK_CYCLES(TICKS)) i_dut (
      .mclk_i(mclk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .input_value_i(xin), .primary_output_o(y1),
      .secondary_output_o(y2), .result_valid_o(valid));
   input_front_end i_src (.mclk_i(mclk), .resetn_i(resetn), .level_i(level), .value_o(xin));

   always #20 mclk = ~mclk;

   task automatic print_verdict();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         n_fail++;
         print_verdict();
      end
   endtask

   // Results are sampled on the falling edge so registered outputs have settled.
   task automatic steps(input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         k = 0;
         do begin
            @(negedge mclk);
            k++;
         end while (valid !== 1'b1 && k < 100);
         if (k >= 100) begin
            n_fail++;
            print_verdict();
         end
      end
   endtask

   // Changing the level just after a result keeps it clear of the next sample edge.
   task automatic go(input logic signed [15:0] x);
      steps(1);
      @(posedge mclk);
      level <= x;
   endtask

   task automatic tryv(input logic signed [15:0] x, input logic signed [15:0] y);
      go(x);
      steps(2);
      `CHK(y1, y)
      `CHK(y2, y)
   endtask

   initial begin
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, 8'(4 * i), '0);
         `CHK(q, rst_v[i])
      end
      apb(1'b0, 8'h30, '0);
      `CHK({e, q}, 33'h100000000)
      apb(1'b0, 8'h06, '0);
      `CHK(e, 1'b1)
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, OFS_AVG_TIME, tq_in[i]);
         apb(1'b0, OFS_AVG_TIME, '0);
         `CHK(q, tq_out[i])
      end
      apb(1'b1, OFS_LIM_HI, 32'h4e20);
      apb(1'b0, OFS_LIM_HI, '0);
      `CHK(q, 32'h2968)
      apb(1'b1, OFS_LIM_LO, 32'hfffffda8);
      apb(1'b0, OFS_LIM_LO, '0);
      `CHK(q, 32'hfffffda8)
      apb(1'b1, OFS_LIM_HI, 32'h1f40);
      apb(1'b1, OFS_LIM_LO, 32'h7d0);
      apb(1'b1, OFS_MODE, 32'h5);
      tryv(16'sh1388, 16'sh1388);
      tryv(16'sh2328, 16'sh1f40);
      tryv(16'sh03e8, 16'sh07d0);
      apb(1'b1, OFS_LIM_HI, 32'h3e8);
      apb(1'b1, OFS_LIM_LO, 32'hbb8);
      tryv(16'sh1388, 16'sh03e8);
      apb(1'b0, OFS_OUTPUT, '0);
      `CHK(q, 32'h3e8)
      apb(1'b1, OFS_FUNC_TC, 32'h0);
      apb(1'b1, OFS_MODE, 32'h2);
      tryv(16'sh2ee0, 16'sh2968);
      tryv(-16'sh03e8, -16'sh0258);
      tryv(16'sh10e1, 16'sh10e1);
      apb(1'b1, OFS_MODE, 32'h3);
      tryv(16'sh0, 16'sh0);
      apb(1'b1, OFS_FUNC_TC, 32'ha);
      go(16'sh03e8);
      steps(1);
      `CHK(y1 > 16'sh05dc, 1'b1)
      steps(80);
      `CHK(y1 >= 16'sh03e7 && y1 <= 16'sh03e9, 1'b1)
      apb(1'b1, OFS_RATE_UP, 32'h1b58);
      apb(1'b1, OFS_RATE_DN, 32'h1b58);
      apb(1'b1, OFS_MODE, 32'h4);
      tryv(16'sh0bb8, 16'sh0bb8);
      tryv(16'sh0, 16'sh0);
      apb(1'b1, OFS_RATE_UP, 32'h3e8);
      go(16'sh2328);
      steps(1);
      for (int i = 0; i < 3; i++) begin
         prev = y1;
         steps(1);
         `CHK(y1 - prev >= 16'sh10 && y1 - prev <= 16'sh11, 1'b1)
      end
      apb(1'b1, OFS_VEL_TIME, 32'h0);
      apb(1'b1, OFS_MODE, 32'h6);
      tryv(16'sh03e8, 16'sh1388);
      go(16'sh0bb8);
      steps(1);
      `CHK(y1, 16'sh1770)
      go(16'sh03e8);
      steps(1);
      `CHK(y1, 16'sh0fa0)
      apb(1'b1, OFS_MODE, 32'h0);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, OFS_AVG_TIME, 32'(n_win[i]));
         steps(n_win[i] - 3);
         `CHK(y1 < 16'sh03e8, 1'b1)
         steps(8);
         `CHK(y1, 16'sh03e8)
      end
      apb(1'b1, OFS_AVG_TIME, 32'h50);
      steps(1);
      for (int i = 0; i < 4; i++) begin
         prev = y1;
         steps(1);
         `CHK(y1 != prev, 1'b1)
      end
      apb(1'b1, OFS_DEAD_TIME, 32'h14);
      apb(1'b1, OFS_MODE, 32'h1);
      go(16'sh07d0);
      steps(10);
      `CHK(y1, 16'sh0)
      steps(15);
      `CHK(y1, 16'sh07d0)
      apb(1'b1, OFS_MODE, 32'h0);
      apb(1'b1, OFS_AVG_TIME, 32'h0);
      tryv(16'sh0, 16'sh0);
      apb(1'b1, OFS_IN_LAG, 32'ha);
      go(16'sh044c);
      steps(1);
      `CHK(y1 > 16'sh0 && y1 < 16'sh044c, 1'b1)
      apb(1'b1, OFS_MODE, 32'h7);
      tryv(16'sh0fa0, 16'sh0fa0);
      print_verdict();
   end
endmodule

// ---- verilog/process_signal_computer.sv ----
`timescale 1ns/100ps
module process_signal_computer #(
   parameter int unsigned TICK_CYCLES = process_signal_computer_pkg::TICK_CYCLES_DEF
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [process_signal_computer_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [process_signal_computer_pkg::DATA_W-1:0] pwdata_i,
   output logic [process_signal_computer_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic signed [process_signal_computer_pkg::PCT_W-1:0] input_value_i,
   output logic signed [process_signal_computer_pkg::PCT_W-1:0] primary_output_o,
   output logic signed [process_signal_computer_pkg::PCT_W-1:0] secondary_output_o,
   output logic result_valid_o
);
   import process_signal_computer_pkg::*;

   typedef struct packed {
      fsm_t fsm;
      logic [31:0] tick;
      logic [2:0] mode;
      logic [TIME_W-1:0] avg_t;
      logic [TIME_W-1:0] dead_t;
      logic [TC_W-1:0] in_lag;
      logic [TC_W-1:0] func_tc;
      logic [RATE_W-1:0] rate_up;
      logic [RATE_W-1:0] rate_dn;
      logic signed [PCT_W-1:0] lim_hi;
      logic signed [PCT_W-1:0] lim_lo;
      logic [TIME_W-1:0] vel_t;
      logic signed [PCT_W-1:0] x;
      logic signed [31:0] filt;
      logic [BUF_DEPTH-1:0][PCT_W-1:0] buf_mem;
      logic [PTR_W-1:0] ptr;
      logic signed [31:0] sum;
      logic [TIME_W-1:0] icnt;
      logic [TIME_W-1:0] rem;
      logic signed [31:0] target;
      logic signed [31:0] interp;
      logic signed [31:0] rl;
      logic signed [PCT_W-1:0] xl;
      logic signed [31:0] res;
      logic signed [PCT_W-1:0] primary;
      logic signed [PCT_W-1:0] secondary;
      logic valid;
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } state_t;

   state_t s_q;
   state_t s_d;

   if (TICK_CYCLES < 4) begin : g_tick_check
      $error("TICK_CYCLES must be at least 4 so one step fits in a period.");
   end

   // Truncating divide; a zero divisor passes the dividend through.
   function automatic logic signed [31:0] sdiv(input logic signed [31:0] a,
                                               input logic [TIME_W-1:0] b);
      if (b == '0) begin
         return a;
      end
      return a / $signed({8'h00, b});
   endfunction

   // Times keep four significant digits; steps of 0.1 s only up to 4 s.
   function automatic logic [TIME_W-1:0] quant_time(input logic [31:0] v);
      logic [31:0] c;
      c = (v > {8'h00, TIME_MAX}) ? {8'h00, TIME_MAX} : v;
      if (c <= {8'h00, TIME_FINE_MAX}) begin
         return c[TIME_W-1:0];
      end else if (c < 32'h000186a0) begin
         return TIME_W'(c - (c % 32'h0000000a));
      end else if (c < 32'h000f4240) begin
         return TIME_W'(c - (c % 32'h00000064));
      end
      return TIME_W'(c - (c % 32'h000003e8));
   endfunction

   function automatic logic [TC_W-1:0] clamp_tc(input logic [31:0] v);
      return (v > {19'h00000, TC_MAX}) ? TC_MAX : v[TC_W-1:0];
   endfunction

   function automatic logic [RATE_W-1:0] clamp_rate(input logic [31:0] v);
      if (v < {16'h0000, RATE_MIN}) begin
         return RATE_MIN;
      end else if (v > {16'h0000, RATE_OPEN}) begin
         return RATE_OPEN;
      end
      return v[RATE_W-1:0];
   endfunction

   function automatic logic signed [PCT_W-1:0] clamp_pct(input logic signed [31:0] v);
      if (v < 32'(PCT_MIN)) begin
         return PCT_MIN;
      end else if (v > 32'(PCT_MAX)) begin
         return PCT_MAX;
      end
      return v[PCT_W-1:0];
   endfunction

   // Short settings of 1, 2 and 3 s use a shorter window.
   function automatic logic [PTR_W-1:0] win_len(input logic [TIME_W-1:0] len);
      case (len)
         24'h00000a: return 6'h0a;
         24'h000014: return 6'h14;
         24'h00001e: return 6'h1e;
         default: return 6'(BUF_DEPTH);
      endcase
   endfunction

   // Per-step slope in hundredths with FRAC_W fraction bits.
   function automatic logic signed [31:0] rate_step(input logic [RATE_W-1:0] r);
      return signed'(32'(({16'h0000, r} * 32'(RATE_NUM)) / 32'(RATE_DEN)));
   endfunction

   function automatic logic [DATA_W-1:0] sext(input logic signed [PCT_W-1:0] v);
      return {{(DATA_W - PCT_W){v[PCT_W-1]}}, v};
   endfunction

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      return (a[1:0] == 2'b00) && (a <= OFS_INPUT);
   endfunction

   function automatic logic [DATA_W-1:0] reg_read(input logic [ADDR_W-1:0] a,
                                                  input state_t s);
      case (a)
         OFS_MODE: return {29'h0, s.mode};
         OFS_AVG_TIME: return {8'h00, s.avg_t};
         OFS_DEAD_TIME: return {8'h00, s.dead_t};
         OFS_IN_LAG: return {19'h00000, s.in_lag};
         OFS_FUNC_TC: return {19'h00000, s.func_tc};
         OFS_RATE_UP: return {16'h0000, s.rate_up};
         OFS_RATE_DN: return {16'h0000, s.rate_dn};
         OFS_LIM_HI: return sext(s.lim_hi);
         OFS_LIM_LO: return sext(s.lim_lo);
         OFS_VEL_TIME: return {8'h00, s.vel_t};
         OFS_OUTPUT: return sext(s.primary);
         OFS_INPUT: return sext(s.x);
         default: return '0;
      endcase
   endfunction

   always_comb begin
      logic signed [31:0] fin;
      logic signed [31:0] diff;
      logic signed [31:0] step;
      logic signed [31:0] oldest;
      logic [TIME_W-1:0] len;
      logic [TIME_W-1:0] interval;
      logic [TIME_W-1:0] tc;
      logic [PTR_W-1:0] n;
      logic clr;
      fin = '0;
      diff = '0;
      step = '0;
      oldest = '0;
      len = '0;
      interval = '0;
      tc = '0;
      n = '0;
      clr = 1'b0;
      s_d = s_q;
      s_d.valid = 1'b0;

      // The tick also runs through the pipeline states, so results come every TICK_CYCLES.
      if (s_q.tick == 32'(TICK_CYCLES - 1)) begin
         s_d.tick = '0;
      end else begin
         s_d.tick = s_q.tick + 32'h1;
      end
      case (s_q.fsm)
         ST_WAIT: begin
            if (s_q.tick == 32'(TICK_CYCLES - 1)) begin
               s_d.x = input_value_i;
               s_d.fsm = ST_FILTER;
            end
         end
         ST_FILTER: begin
            // One lag state serves the input filter and the lag and lead functions.
            if (s_q.mode == MODE_LAG || s_q.mode == MODE_LEAD) begin
               tc = TIME_W'(s_q.func_tc);
            end else begin
               tc = TIME_W'(s_q.in_lag);
            end
            diff = (32'(s_q.x) <<< FRAC_W) - s_q.filt;
            s_d.filt = s_q.filt + sdiv(diff, tc + 24'h1);
            s_d.fsm = ST_COMPUTE;
         end
         ST_COMPUTE: begin
            fin = s_q.filt >>> FRAC_W;
            s_d.fsm = ST_OUT;
            case (s_q.mode)
               MODE_AVG, MODE_DEAD: begin
                  len = (s_q.mode == MODE_AVG) ? s_q.avg_t : s_q.dead_t;
                  if (len == '0) begin
                     s_d.interp = fin;
                     s_d.res = fin;
                  end else begin
                     n = win_len(len);
                     interval = len / {18'h00000, n};
                     if (interval == '0) begin
                        interval = 24'h1;
                     end
                     if (s_q.icnt == '0) begin
                        oldest = 32'(signed'(s_q.buf_mem[s_q.ptr]));
                        s_d.buf_mem[s_q.ptr] = fin[PCT_W-1:0];
                        s_d.sum = s_q.sum - oldest + fin;
                        s_d.ptr = (s_q.ptr >= n - 6'h1) ? '0 : s_q.ptr + 6'h1;
                        if (s_q.mode == MODE_AVG) begin
                           s_d.target = s_d.sum / $signed({26'h0, n});
                        end else begin
                           s_d.target = oldest;
                        end
                        s_d.rem = interval;
                        s_d.icnt = interval - 24'h1;
                     end else begin
                        s_d.icnt = s_q.icnt - 24'h1;
                     end
                     // Spread the move over the remaining steps so it ends on target.
                     if (s_d.rem == '0) begin
                        s_d.interp = s_d.target;
                     end else begin
                        step = sdiv(s_d.target - s_q.interp, s_d.rem);
                        s_d.interp = s_q.interp + step;
                        s_d.rem = s_d.rem - 24'h1;
                     end
                     s_d.res = s_d.interp;
                  end
               end
               MODE_LAG: begin
                  s_d.res = fin;
               end
               MODE_LEAD: begin
                  s_d.res = (32'(s_q.x) <<< 1) - fin;
               end
               MODE_RATE: begin
                  diff = (32'(s_q.x) <<< FRAC_W) - s_q.rl;
                  if (diff > 0) begin
                     step = rate_step(s_q.rate_up);
                     if (s_q.rate_up >= RATE_OPEN || diff <= step) begin
                        s_d.rl = 32'(s_q.x) <<< FRAC_W;
                     end else begin
                        s_d.rl = s_q.rl + step;
                     end
                  end else if (diff < 0) begin
                     step = rate_step(s_q.rate_dn);
                     if (s_q.rate_dn >= RATE_OPEN || -diff <= step) begin
                        s_d.rl = 32'(s_q.x) <<< FRAC_W;
                     end else begin
                        s_d.rl = s_q.rl - step;
                     end
                  end
                  s_d.res = s_d.rl >>> FRAC_W;
               end
               MODE_LIMIT: begin
                  if (s_q.lim_hi < s_q.lim_lo) begin
                     s_d.res = 32'(s_q.lim_hi);
                  end else if (s_q.x > s_q.lim_hi) begin
                     s_d.res = 32'(s_q.lim_hi);
                  end else if (s_q.x < s_q.lim_lo) begin
                     s_d.res = 32'(s_q.lim_lo);
                  end else begin
                     s_d.res = 32'(s_q.x);
                  end
               end
               MODE_VEL: begin
                  s_d.res = VEL_BIAS + ((fin - 32'(s_q.xl)) / 32'sd2);
                  if (s_q.icnt == '0) begin
                     s_d.xl = fin[PCT_W-1:0];
                     s_d.icnt = (s_q.vel_t == '0) ? '0 : s_q.vel_t - 24'h1;
                  end else begin
                     s_d.icnt = s_q.icnt - 24'h1;
                  end
               end
               default: begin
                  s_d.res = 32'(s_q.x);
               end
            endcase
         end
         ST_OUT: begin
            s_d.primary = clamp_pct(s_q.res);
            s_d.secondary = clamp_pct(s_q.res);
            s_d.valid = 1'b1;
            s_d.fsm = ST_WAIT;
         end
         default: begin
            s_d.fsm = ST_WAIT;
         end
      endcase

      // Answer in the setup cycle so every access phase completes in one cycle.
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      if (psel_i && !penable_i) begin
         s_d.pready = 1'b1;
         s_d.prdata = reg_read(paddr_i, s_q);
         s_d.pslverr = !addr_ok(paddr_i);
      end
      if (psel_i && penable_i && s_q.pready && pwrite_i && !s_q.pslverr) begin
         case (paddr_i)
            OFS_MODE: begin
               s_d.mode = pwdata_i[2:0];
               clr = 1'b1;
            end
            OFS_AVG_TIME: begin
               s_d.avg_t = quant_time(pwdata_i);
               clr = 1'b1;
            end
            OFS_DEAD_TIME: begin
               s_d.dead_t = quant_time(pwdata_i);
               clr = 1'b1;
            end
            OFS_IN_LAG: s_d.in_lag = clamp_tc(pwdata_i);
            OFS_FUNC_TC: s_d.func_tc = clamp_tc(pwdata_i);
            OFS_RATE_UP: s_d.rate_up = clamp_rate(pwdata_i);
            OFS_RATE_DN: s_d.rate_dn = clamp_rate(pwdata_i);
            OFS_LIM_HI: s_d.lim_hi = clamp_pct(signed'(pwdata_i));
            OFS_LIM_LO: s_d.lim_lo = clamp_pct(signed'(pwdata_i));
            OFS_VEL_TIME: s_d.vel_t = quant_time(pwdata_i);
            default: begin
            end
         endcase
      end
      // A new window length leaves stale samples, so the history restarts empty.
      if (clr) begin
         s_d.buf_mem = '0;
         s_d.sum = '0;
         s_d.ptr = '0;
         s_d.icnt = '0;
         s_d.rem = '0;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '0;
         s_q.fsm <= ST_WAIT;
         s_q.mode <= MODE_RST;
         s_q.avg_t <= AVG_T_RST;
         s_q.dead_t <= DEAD_T_RST;
         s_q.in_lag <= IN_LAG_RST;
         s_q.func_tc <= FUNC_TC_RST;
         s_q.rate_up <= RATE_RST;
         s_q.rate_dn <= RATE_RST;
         s_q.lim_hi <= LIM_HI_RST;
         s_q.lim_lo <= LIM_LO_RST;
         s_q.vel_t <= VEL_T_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Values are signed hundredths of a percent; the filter keeps extra fraction bits.
   assign prdata_o = s_q.prdata;
   assign pready_o = s_q.pready;
   assign pslverr_o = s_q.pslverr;
   assign primary_output_o = s_q.primary;
   assign secondary_output_o = s_q.secondary;
   assign result_valid_o = s_q.valid;
endmodule
